// File: sbw_top.sv
// Break, wake and synchronous master transmit part of a serial port
module sbw_top import sbw_pkg::*; (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic rx_data_pin_i,
    output logic rx_data_pin_o,
    output logic rx_data_pin_oe_n_o,
    output logic tx_clock_pin_o,
    output logic tx_clock_pin_oe_n_o,
    output logic rx_ready_flag_o,
    output logic rx_idle_status_o,
    output logic autobaud_arm_o,
    output logic baud_tick_o
);

    sbw_ctrl_t ctrl; // Control register
    logic [15:0] baud_div; // Oversample divisor
    logic tick; // Oversample tick
    logic rx_s; // Synchronised receive line
    logic rx_q; // Previous synchronised level
    logic rx_fall; // Falling edge of receive line
    logic rx_rise; // Rising edge of receive line

    logic [7:0] tx_holding_reg; // Byte waiting for the shifter
    logic hold_full; // Holding register occupied
    logic [13:0] tx_shift_reg; // Bits still to send
    logic [3:0] bits_left; // Bits left including current
    logic [3:0] tx_cnt; // Transmit oversample count
    logic brk_active; // Frame in shifter is a break
    logic ck_act; // Shift clock in its active half
    logic ser_line; // Serial data level
    sbw_tx_state_t tx_state; // Transmit state

    sbw_rx_state_t rx_state; // Receive state
    logic [3:0] rx_cnt; // Receive oversample count
    logic [2:0] rx_bit; // Received data bit index
    logic [7:0] rx_shift; // Receive shifter
    logic [7:0] rx_data_reg; // Last received byte
    logic framing_error_flag; // Stop bit seen low
    logic rx_ready_flag; // Receive ready, sticky
    logic rx_idle; // Receiver idle, registered

    logic sync_master; // Synchronous master selected
    logic sync_tx_mode; // Synchronous master transmitting
    logic rx_enable; // Asynchronous receiver allowed
    logic tx_load; // Holding register moves to shifter
    logic tx_bit_end; // Asynchronous bit period ends
    logic tx_half_end; // Synchronous half period ends
    logic tx_done; // Last bit of a frame completed
    logic brk_done; // Break stop bit completed
    logic rx_done; // Receive stop bit sampled
    logic wake_evt; // Wake event while armed
    sbw_stat_t stat; // Status word for reads

    // Receive line to clock domain
    sbw_sync3 u_rx_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i(rx_data_pin_i),
        .q_o(rx_s)
    );

    // Oversample tick source
    sbw_baud u_baud (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .div_i(baud_div),
        .tick_o(tick)
    );

    // Edge finder on the synchronised line
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_q <= 1'b1;
        end else begin
            rx_q <= rx_s;
        end
    end

    assign rx_fall = rx_q & ~rx_s;
    assign rx_rise = ~rx_q & rx_s;

    // Mode decode
    always_comb begin
        sync_master = ctrl.sync_sel & ctrl.clock_source_master
                      & ctrl.port_enable_bit;
        sync_tx_mode = sync_master & ~ctrl.single_receive_enable
                       & ~ctrl.continuous_receive_enable;
        rx_enable = ctrl.port_enable_bit & ~ctrl.sync_sel
                    & ctrl.continuous_receive_enable
                    & ~ctrl.wake_arm;
        wake_evt = ctrl.wake_arm & rx_fall;
    end

    // Transfer and timing strobes of the transmitter
    always_comb begin
        tx_load = (tx_state == TX_IDLE) & hold_full & ctrl.tx_enable_bit
                  & ctrl.port_enable_bit
                  & (~ctrl.sync_sel | sync_tx_mode);
        tx_bit_end = tick & (tx_cnt == OVS_LAST);
        tx_half_end = tick & (tx_cnt == HALF_LAST);
        tx_done = (tx_state == TX_ASYNC) & tx_bit_end
                  & (bits_left == 4'h1);
        brk_done = tx_done & brk_active;
    end

    // Control register, with hardware clears after software writes
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl <= sbw_ctrl_t'(CTRL_RST);
        end else begin
            if (wr_i && addr_i == REG_CTRL) begin
                // Auto-baud may be armed alongside wake
                ctrl <= sbw_ctrl_t'(wdata_i[9:0]);
            end
            if (ctrl.wake_arm && rx_rise) begin
                // End of break disarms wake
                ctrl.wake_arm <= 1'b0;
            end
            if (brk_done) begin
                ctrl.send_break_bit <= 1'b0;
            end
        end
    end

    // Baud divisor register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            baud_div <= BAUD_RST;
        end else if (wr_i && addr_i == REG_BAUD) begin
            baud_div <= wdata_i;
        end
    end

    // Holding register; a write overwrites, software waits for empty
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_holding_reg <= 8'h00;
            hold_full <= 1'b0;
        end else if (wr_i && addr_i == REG_TXD) begin
            tx_holding_reg <= wdata_i[7:0];
            hold_full <= 1'b1;
        end else if (tx_load) begin
            hold_full <= 1'b0;
        end
    end

    // Transmit shifter: asynchronous frames, breaks, synchronous bytes
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_state <= TX_IDLE;
            tx_shift_reg <= 14'h0000;
            bits_left <= 4'h0;
            tx_cnt <= 4'h0;
            brk_active <= 1'b0;
            ck_act <= 1'b0;
            ser_line <= 1'b1;
        end else begin
            if (tick) begin
                tx_cnt <= tx_cnt + 4'h1;
            end
            case (tx_state)
                TX_IDLE: begin
                    ck_act <= 1'b0;
                    if (tx_load && ctrl.sync_sel) begin
                        // No start or stop bits; first bit out now
                        tx_state <= TX_SYNC;
                        ser_line <= tx_holding_reg[0];
                        tx_shift_reg <= {7'h00, tx_holding_reg[7:1]};
                        bits_left <= SYNC_BITS;
                        ck_act <= 1'b1;
                        tx_cnt <= 4'h0;
                    end else if (tx_load && ctrl.send_break_bit) begin
                        // Written value ignored, zeros sent
                        tx_state <= TX_ASYNC;
                        ser_line <= BRK_FRAME[0];
                        tx_shift_reg <= BRK_FRAME >> 1;
                        bits_left <= BRK_BITS;
                        brk_active <= 1'b1;
                        tx_cnt <= 4'h0;
                    end else if (tx_load) begin
                        // Start low, data, stop high
                        tx_state <= TX_ASYNC;
                        ser_line <= 1'b0;
                        tx_shift_reg <= {6'h01, tx_holding_reg};
                        bits_left <= CHAR_BITS;
                        brk_active <= 1'b0;
                        tx_cnt <= 4'h0;
                    end
                end
                TX_ASYNC: begin
                    if (tx_bit_end) begin
                        if (bits_left == 4'h1) begin
                            // Stop bit done; held byte loads next
                            tx_state <= TX_IDLE;
                            ser_line <= 1'b1;
                            brk_active <= 1'b0;
                        end else begin
                            ser_line <= tx_shift_reg[0];
                            tx_shift_reg <= tx_shift_reg >> 1;
                        end
                        bits_left <= bits_left - 4'h1;
                    end
                end
                TX_SYNC: begin
                    if (tx_half_end) begin
                        tx_cnt <= 4'h0;
                        if (ck_act) begin
                            // Trailing edge ends one bit
                            ck_act <= 1'b0;
                            bits_left <= bits_left - 4'h1;
                            if (bits_left == 4'h1) begin
                                tx_state <= TX_IDLE;
                            end
                        end else begin
                            // Leading edge, next bit, low bit first
                            ck_act <= 1'b1;
                            ser_line <= tx_shift_reg[0];
                            tx_shift_reg <= tx_shift_reg >> 1;
                        end
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // Asynchronous receiver, held idle while wake is armed
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_state <= RX_IDLE;
            rx_cnt <= 4'h0;
            rx_bit <= 3'h0;
            rx_shift <= 8'h00;
        end else if (!rx_enable) begin
            rx_state <= RX_IDLE;
        end else begin
            if (tick) begin
                rx_cnt <= rx_cnt + 4'h1;
            end
            case (rx_state)
                RX_IDLE: begin
                    if (rx_fall) begin
                        rx_state <= RX_START;
                        rx_cnt <= 4'h0;
                    end
                end
                RX_START: begin
                    if (tick && rx_cnt == HALF_LAST) begin
                        // Mid start bit; a high line was a glitch
                        rx_cnt <= 4'h0;
                        rx_bit <= 3'h0;
                        rx_state <= rx_s ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (tick && rx_cnt == OVS_LAST) begin
                        rx_shift <= {rx_s, rx_shift[7:1]};
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == RX_LAST_BIT) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (tick && rx_cnt == OVS_LAST) begin
                        rx_state <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    assign rx_done = rx_enable & (rx_state == RX_STOP) & tick
                     & (rx_cnt == OVS_LAST);

    // Received byte and framing error; a break gives zero and error
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_data_reg <= 8'h00;
            framing_error_flag <= 1'b0;
        end else if (rx_done) begin
            rx_data_reg <= rx_shift;
            framing_error_flag <= ~rx_s;
        end
    end

    // Receive ready flag; a setting event wins over the read clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_ready_flag <= 1'b0;
        end else if (wake_evt || rx_done) begin
            // Wake edge, then the byte after it, each raise it
            rx_ready_flag <= 1'b1;
        end else if (rd_i && addr_i == REG_RXD) begin
            rx_ready_flag <= 1'b0;
        end
    end

    // Receiver idle indication, one cycle behind the state
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_idle <= 1'b1;
        end else begin
            rx_idle <= (rx_state == RX_IDLE);
        end
    end

    // Status word
    always_comb begin
        stat.rx_idle_status = rx_idle;
        stat.framing_error_flag = framing_error_flag;
        stat.rx_ready_flag = rx_ready_flag;
        stat.tx_buffer_empty_flag = ~hold_full;
        // Busy during breaks just as for characters
        stat.tx_shift_empty = (tx_state == TX_IDLE);
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                REG_CTRL: rdata_o <= {6'h00, ctrl};
                REG_STAT: rdata_o <= {11'h000, stat};
                REG_TXD: rdata_o <= {8'h00, tx_holding_reg};
                REG_RXD: rdata_o <= {8'h00, rx_data_reg};
                REG_BAUD: rdata_o <= baud_div;
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // Pin drivers; enables are low while driving
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_clock_pin_o <= 1'b1;
            tx_clock_pin_oe_n_o <= 1'b1;
            rx_data_pin_o <= 1'b1;
            rx_data_pin_oe_n_o <= 1'b1;
        end else if (sync_master) begin
            // Idle level equals polarity; active half inverts it
            tx_clock_pin_o <= ctrl.clock_polarity_bit ^ ck_act;
            tx_clock_pin_oe_n_o <= 1'b0;
            rx_data_pin_o <= ser_line;
            rx_data_pin_oe_n_o <= ~sync_tx_mode;
        end else begin
            // Not sync master: transmit line on the clock pin
            tx_clock_pin_o <= ser_line;
            tx_clock_pin_oe_n_o <= ~(ctrl.port_enable_bit
                                     & ctrl.tx_enable_bit);
            rx_data_pin_o <= 1'b1;
            rx_data_pin_oe_n_o <= 1'b1;
        end
    end

    // Side outputs for the neighbouring logic
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_ready_flag_o <= 1'b0;
            rx_idle_status_o <= 1'b1;
            autobaud_arm_o <= 1'b0;
            baud_tick_o <= 1'b0;
        end else begin
            rx_ready_flag_o <= rx_ready_flag;
            rx_idle_status_o <= rx_idle;
            autobaud_arm_o <= ctrl.autobaud_arm;
            baud_tick_o <= tick;
        end
    end

endmodule

// File: sbw_pkg.sv
// What this block does
// - Armed wake event raises receive ready flag
// - Rising data line clears wake arm
// - Receive data read clears ready flag
// - Break is start, twelve zeros, stop
// - Send break plus write starts break
// - Send break clears after break stop
// - Queued sync byte follows break automatically
// - Shift empty status covers break too
// - Received break gives flag, error, zero
// - Wake edge interrupt, then next byte
// - Auto-baud arm accepted with wake arm
// - Synchronous mode: no start, stop bits
// - Sync master needs sync, master, enable
// - Both receive enables clear means transmit
// - Master drives shift clock pin
// - One clock cycle per data bit
// - Polarity sets idle level and edge
// - Sync transmit drives data pin
// - Busy shifter holds next byte waiting
// - Data changes on leading clock edge
// - Wake event is falling data line
// - Wake arm suspends normal reception
package sbw_pkg;

    // Register port widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STAT = 3'h1;
    localparam logic [2:0] REG_TXD = 3'h2;
    localparam logic [2:0] REG_RXD = 3'h3;
    localparam logic [2:0] REG_BAUD = 3'h4;

    // Control register layout, bit 0 is the transmit enable
    typedef struct packed {
        logic autobaud_arm;
        logic wake_arm;
        logic clock_polarity_bit;
        logic continuous_receive_enable;
        logic single_receive_enable;
        logic port_enable_bit;
        logic clock_source_master;
        logic sync_sel;
        logic send_break_bit;
        logic tx_enable_bit;
    } sbw_ctrl_t;

    // Status register layout, bit 0 is shift empty
    typedef struct packed {
        logic rx_idle_status;
        logic framing_error_flag;
        logic rx_ready_flag;
        logic tx_buffer_empty_flag;
        logic tx_shift_empty;
    } sbw_stat_t;

    // Reset values
    localparam logic [9:0] CTRL_RST = 10'h000;
    localparam logic [15:0] BAUD_RST = 16'h0067;

    // Oversampling: sixteen ticks per bit, eight per half
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] HALF_LAST = 4'h7;

    // Bit counts of the frames
    localparam logic [3:0] CHAR_BITS = 4'hA;
    localparam logic [3:0] BRK_BITS = 4'hE;
    localparam logic [3:0] SYNC_BITS = 4'h8;
    localparam logic [2:0] RX_LAST_BIT = 3'h7;

    // Break frame, start and twelve zeros then stop at the top
    localparam logic [13:0] BRK_FRAME = 14'h2000;

    // Transmit states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ASYNC = 2'b01,
        TX_SYNC = 2'b10
    } sbw_tx_state_t;

    // Receive states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } sbw_rx_state_t;

endpackage

// File: sbw_sync3.sv
// Three-stage input synchroniser; output moves when stages two and three
// agree, so a single metastable sample never reaches the logic
module sbw_sync3 import sbw_pkg::*; (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic d_i,
    output logic q_o
);

    logic s1; // First stage, read only by s2
    logic s2; // Second stage
    logic s3; // Third stage

    // Shift chain, idle line level is high
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a level once two stages agree
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q_o <= 1'b1;
        end else if (s2 == s3) begin
            q_o <= s3;
        end
    end

endmodule

// File: sbw_baud.sv
// Oversample tick divider: one pulse every div_i + 1 clocks
module sbw_baud import sbw_pkg::*; (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [15:0] div_i,
    output logic tick_o
);

    logic [15:0] cnt; // Cycles since last tick

    // Count up and pulse on reaching the divisor
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt >= div_i) begin
            cnt <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            tick_o <= 1'b0;
        end
    end

endmodule

// File: sbw_top_sva.sv
// Port checker for the break, wake and sync master block
module sbw_top_chk import sbw_pkg::*; (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic rx_data_pin_i,
    input wire logic rx_data_pin_o,
    input wire logic rx_data_pin_oe_n_o,
    input wire logic tx_clock_pin_o,
    input wire logic tx_clock_pin_oe_n_o,
    input wire logic rx_ready_flag_o,
    input wire logic rx_idle_status_o,
    input wire logic autobaud_arm_o,
    input wire logic baud_tick_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // Both drivers off and read data quiet once reset lets go
    rst_idle_a: assert property ($fell(srst_i) |->
        rx_data_pin_oe_n_o && tx_clock_pin_oe_n_o && rdata_o == '0)
        else $error("pins driven after reset");
    data_drv_a: assert property (!rx_data_pin_oe_n_o |->
        !tx_clock_pin_oe_n_o) else $error("data driven without clock");
    // Data only moves together with a clock edge
    lead_edge_a: assert property (!rx_data_pin_oe_n_o
        && !$past(rx_data_pin_oe_n_o) && $changed(rx_data_pin_o)
        |-> $changed(tx_clock_pin_o)) else $error("data moved off edge");
    ck_hold_a: assert property (!rx_data_pin_oe_n_o
        && !$past(rx_data_pin_oe_n_o) && $changed(tx_clock_pin_o)
        |=> $stable(tx_clock_pin_o)) else $error("clock half too short");
    rd_stand_a: assert property (!$past(rd_i) |-> rdata_o == '0)
        else $error("read data held too long");
    // Guarded so that no new event can set the flag meanwhile
    rd_clear_a: assert property (rd_i && addr_i == REG_RXD
        && rx_idle_status_o && rx_data_pin_i |-> ##2 !rx_ready_flag_o)
        else $error("ready not cleared by read");
    stat_flag_a: assert property (rd_i && addr_i == REG_STAT
        |=> rdata_o[2] == rx_ready_flag_o) else $error("ready bit mismatch");
    abd_copy_a: assert property (wr_i && addr_i == REG_CTRL
        ##1 !(wr_i && addr_i == REG_CTRL)
        |=> autobaud_arm_o == $past(wdata_i[9], 2))
        else $error("autobaud output wrong");
    byte_rd_a: assert property (rd_i && addr_i == REG_RXD
        |=> rdata_o[15:8] == 8'h00) else $error("receive data above byte");
endmodule
bind sbw_top sbw_top_chk chk (.clk_i(clk_i), .srst_i(srst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rx_data_pin_i(rx_data_pin_i),
    .rx_data_pin_o(rx_data_pin_o), .rx_data_pin_oe_n_o(rx_data_pin_oe_n_o),
    .tx_clock_pin_o(tx_clock_pin_o),
    .tx_clock_pin_oe_n_o(tx_clock_pin_oe_n_o),
    .rx_ready_flag_o(rx_ready_flag_o), .rx_idle_status_o(rx_idle_status_o),
    .autobaud_arm_o(autobaud_arm_o), .baud_tick_o(baud_tick_o));

// File: sbw_node.sv
// Line side: a bus node sending frames, or a sync slave shifting in
module sbw_node (
    input wire logic ck_i,
    input wire logic ck_oe_n_i,
    input wire logic dt_i,
    input wire logic pol_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    parameter int BIT_NS = 800; // Sixteen clocks a bit at divisor zero
    int edges = 0; // Clock pin changes while driven
    logic [7:0] shreg = 8'h00; // Bits taken at trailing edges
    initial line_o = 1'h1; // Line idles high through its pull-up
    // Slave samples as the clock regains its idle level
    always @(ck_i) begin
        if (ck_oe_n_i === 1'h0) begin
            edges++;
            if (ck_i === pol_i) shreg = {dt_i, shreg[7:1]};
        end
    end
    // Drives a frame first bit first; the line keeps the last bit
    task automatic send(int n, logic [15:0] bits);
        for (int i = 0; i < n; i++) begin
            line_o = bits[i];
            #BIT_NS;
        end
    endtask
endmodule

// File: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sbw_pkg::*;
    logic clk_i = 1'h0;
    logic srst_i = 1'h1;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic [DATA_W-1:0] rdata;
    logic dt, dt_oe_n, ck, ck_oe_n, rdy, abd, nl, tk, idl;
    logic pol = 1'h0; // Polarity the slave model expects
    logic [7:0] b;
    logic q_exp[$]; // Line bits the model predicts
    logic q_got[$]; // Line bits seen mid-bit
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    wire logic line = dt_oe_n ? nl : dt; // Design wins while enabled
    sbw_top dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
        .rx_data_pin_i(line), .rx_data_pin_o(dt),
        .rx_data_pin_oe_n_o(dt_oe_n), .tx_clock_pin_o(ck),
        .tx_clock_pin_oe_n_o(ck_oe_n), .rx_ready_flag_o(rdy),
        .rx_idle_status_o(idl), .autobaud_arm_o(abd), .baud_tick_o(tk));
    sbw_node node (.ck_i(ck), .ck_oe_n_i(ck_oe_n), .dt_i(line),
        .pol_i(pol), .line_o(nl));
    always #25 clk_i = ~clk_i;
    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        samples_checked++;
        if (e !== s) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(logic [2:0] a, logic [15:0] m, logic [15:0] e,
                      string n);
        @(posedge clk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1;
        chk(n, e, rdata & m);
    endtask
    // Samples the transmit pin mid-bit from its first fall
    task automatic grab(int n);
        wait (ck === 1'h0);
        repeat (8) @(posedge clk_i);
        repeat (n) begin
            q_got.push_back(ck);
            repeat (16) @(posedge clk_i);
        end
    endtask
    task automatic push_char(logic [7:0] v);
        q_exp.push_back(1'h0);
        for (int i = 0; i < 8; i++) q_exp.push_back(v[i]);
        q_exp.push_back(1'h1);
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        void'($urandom(4));
        repeat (3) @(posedge clk_i);
        srst_i <= 1'h0;
        rd(REG_CTRL, 16'hFFFF, 16'(CTRL_RST), "ctrl");
        rd(REG_STAT, 16'h001F, 16'h0013, "stat");
        rd(REG_BAUD, 16'hFFFF, BAUD_RST, "baud");
        wr(3'h6, 16'hFFFF); // Unmapped, ignored
        rd(3'h6, 16'hFFFF, 16'h0000, "unmapped");
        wr(REG_BAUD, 16'h0000); // Tick every clock, bit is 16 clocks
        $display("test registers done");
        // Break then queued sync byte on the transmit pin
        wr(REG_CTRL, 16'h0013);
        fork
            grab(24);
            begin
                wr(REG_TXD, 16'($urandom));
                wr(REG_TXD, 16'h0055);
                rd(REG_STAT, 16'h0003, 16'h0000, "busy");
            end
        join
        repeat (13) q_exp.push_back(1'h0);
        q_exp.push_back(1'h1);
        push_char(8'h55);
        while (q_exp.size() > 0)
            chk("line", q_exp.pop_front(), q_got.pop_front());
        rd(REG_CTRL, 16'hFFFF, 16'h0011, "ctrl");
        rd(REG_STAT, 16'h0003, 16'h0003, "idle");
        $display("test break done");
        // Sync master transmit in both clock polarities
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            b = 8'($urandom);
            wr(REG_CTRL, 16'h001D | (16'(p) << 7));
            repeat (3) @(posedge clk_i);
            chk("ck idle", 16'(pol), 16'(ck));
            chk("oe", 16'h0000, {14'h0, ck_oe_n, dt_oe_n});
            node.edges = 0;
            wr(REG_TXD, {8'h00, b});
            repeat (150) @(posedge clk_i);
            chk("edges", 16'h0010, 16'(node.edges));
            chk("sync", {8'h00, b}, {8'h00, node.shreg});
            chk("ck rest", 16'(pol), 16'(ck));
        end
        wr(REG_CTRL, 16'h005D);
        repeat (3) @(posedge clk_i);
        chk("rx oe", 16'h0001, {14'h0, ck_oe_n, dt_oe_n});
        chk("tick", 16'h0001, 16'(tk));
        $display("test sync done");
        // Break and a byte arriving from the line
        wr(REG_CTRL, 16'h0050);
        node.send(14, 16'h2000);
        rd(REG_STAT, 16'h000C, 16'h000C, "brk stat");
        rd(REG_RXD, 16'hFFFF, 16'h0000, "brk data");
        b = 8'($urandom);
        node.send(10, {7'h00, 1'h1, b, 1'h0});
        rd(REG_STAT, 16'h000C, 16'h0004, "rx stat");
        rd(REG_RXD, 16'hFFFF, {8'h00, b}, "rx data");
        repeat (2) @(posedge clk_i);
        chk("rdy", 16'h0000, 16'(rdy));
        $display("test receive done");
        // Wake on break, then the following byte
        rd(REG_STAT, 16'h0010, 16'h0010, "rx idle");
        chk("idle pin", 16'h0001, 16'(idl));
        wr(REG_CTRL, 16'h0350);
        repeat (2) @(posedge clk_i);
        chk("abd", 16'h0001, 16'(abd));
        node.send(13, 16'h0000);
        chk("wake", 16'h0001, 16'(rdy));
        rd(REG_STAT, 16'h000C, 16'h0004, "wk stat");
        rd(REG_CTRL, 16'h0100, 16'h0100, "armed");
        node.send(1, 16'h0001);
        rd(REG_CTRL, 16'h0100, 16'h0000, "disarmed");
        rd(REG_RXD, 16'hFFFF, {8'h00, b}, "discard");
        repeat (2) @(posedge clk_i);
        chk("rdy", 16'h0000, 16'(rdy));
        b = 8'($urandom);
        node.send(10, {7'h00, 1'h1, b, 1'h0});
        rd(REG_STAT, 16'h0004, 16'h0004, "next");
        rd(REG_RXD, 16'hFFFF, {8'h00, b}, "next data");
        $display("test wake done");
        report_and_stop();
    end
endmodule
